// ---- sim/rfs_stage_model.sv ----
/*
 * Power stage and load: raises the sensed output on request and pulls it
 * down once every low side has conducted for release_dly + 1 cycles.
 * Assumes requests come from the bench on ref_clk.
 */
`timescale 1ns/1ps
`include "rfs_params.svh"

module rfs_stage_model (
    input wire logic ref_clk,
    input wire logic [`RFS_NCH-1:0] low_side_drive,
    input wire logic ov_fault,
    input wire logic [3:0] release_dly,
    output logic ov_above_trip,
    output logic ov_below_release
);
    logic hot_reg = 1'b0;
    logic fault_q_reg = 1'b0;
    logic [3:0] sink_reg = 4'h0;

    assign ov_above_trip = hot_reg;
    assign ov_below_release = !hot_reg;

    always @(posedge ref_clk) begin
        fault_q_reg <= ov_fault;
        if (hot_reg && low_side_drive == '1)
            sink_reg <= sink_reg + 4'h1;
        else
            sink_reg <= 4'h0;
        // Each new request is a fresh event
        if (ov_fault && !fault_q_reg)
            hot_reg <= 1'b1;
        else if (hot_reg && low_side_drive == '1 && sink_reg == release_dly)
            hot_reg <= 1'b0;
    end
endmodule

// ---- sim/rfs_supervisor_sva.sv ----
/*
 * Port checker for the regulator fault supervisor.
 * Assumes it is bound onto rfs_supervisor, with one ref_clk domain.
 */
`timescale 1ns/1ps
`include "rfs_params.svh"

module rfs_supervisor_sva #(
    parameter int DVT_HOLD_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic enable_in,
    input wire logic por_ok,
    input wire logic ov_above_trip,
    input wire logic uv_below_trip,
    input wire logic dvt_active,
    input wire logic [`RFS_NCH-1:0] ocl_above,
    input wire logic [`RFS_NCH-1:0] high_side_drive,
    input wire logic [`RFS_NCH-1:0] low_side_drive,
    input wire logic power_good_oe,
    input wire logic ss_start,
    input wire logic latched_off,
    input wire logic pre_por_ovp_en,
    input wire logic [2:0] oc_retry_count,
    input wire logic [7:0] ocp_ref_ua,
    input wire logic [7:0] ocl_ref_ua
);
    int quiet_reg;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // --------------------
    // Cycles since the last voltage transition
    // --------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            quiet_reg <= 0;
        else if (dvt_active)
            quiet_reg <= 0;
        else if (quiet_reg < DVT_HOLD_CYCLES + 8)
            quiet_reg <= quiet_reg + 1;
    end

    sequence s_oc_step;
        oc_retry_count != $past(oc_retry_count) && oc_retry_count != 3'h0;
    endsequence
    sequence s_restart;
        ss_start || latched_off;
    endsequence

    property p_ov_clamp;
        (enable_in && por_ok && ov_above_trip && !latched_off) [*4]
            |-> low_side_drive == '1 && high_side_drive == '0 && power_good_oe;
    endproperty
    a_ov_clamp: assert property (p_ov_clamp) else $error("clamp missing");

    property p_latched;
        latched_off |-> high_side_drive == '0 && low_side_drive == '0 && !ss_start;
    endproperty
    a_latched: assert property (p_latched) else $error("latched but active");

    property p_uv;
        uv_below_trip [*4] |-> power_good_oe;
    endproperty
    a_uv: assert property (p_uv) else $error("power good not pulled");

    property p_ocl;
        (ocl_above != '0) [*4] |-> (high_side_drive & $past(ocl_above, 3)) == '0;
    endproperty
    a_ocl: assert property (p_ocl) else $error("high side not blocked");

    property p_oc_restart;
        s_oc_step |-> (high_side_drive == '0 && low_side_drive == '0 && power_good_oe)
            ##1 s_restart;
    endproperty
    a_oc_restart: assert property (p_oc_restart) else $error("no retry");

    property p_oc_fifth;
        oc_retry_count == `RFS_OC_RETRY_LIMIT |-> ##[0:1] latched_off;
    endproperty
    a_oc_fifth: assert property (p_oc_fifth) else $error("no latch on limit");

    property p_boost;
        dvt_active [*3] |-> ocp_ref_ua == `RFS_OCP_BOOST_UA && ocl_ref_ua == `RFS_OCL_BOOST_UA;
    endproperty
    a_boost: assert property (p_boost) else $error("limits not boosted");

    property p_unboost;
        quiet_reg > DVT_HOLD_CYCLES + 3
            |-> ocp_ref_ua == `RFS_OCP_REF_UA && ocl_ref_ua == `RFS_OCL_REF_UA;
    endproperty
    a_unboost: assert property (p_unboost) else $error("limits stay boosted");

    property p_pre_por;
        $fell(por_ok) |-> ##[1:4] pre_por_ovp_en;
    endproperty
    a_pre_por: assert property (p_pre_por) else $error("pre-power path idle");
endmodule

// ---- sim/tb_top.sv ----
/*
 * Self-checking bench for rfs_supervisor with a power stage model.
 * Assumes a shortened transition hold of HOLD cycles.
 */
`timescale 1ns/1ps
`include "rfs_params.svh"

module tb_top;
    localparam int HOLD = 20;
    typedef struct {int sel; logic [10:0] exp;} rfs_note_t;
    logic ref_clk = 1'b0, rstn = 1'b0, enable_in = 1'b0, por_ok = 1'b0;
    logic profile_two = 1'b0, ocp_method_two = 1'b0, ov_fault = 1'b0;
    logic uv_below_trip = 1'b0, uv_above_clear = 1'b1, ocp_avg_above = 1'b0;
    logic ocp_current_monitor_voltage_above = 1'b0, ss_done = 1'b0, dvt_active = 1'b0;
    logic [`RFS_NCH-1:0] ocl_above = '0, pwm_high_req = '0, high_side_drive, low_side_drive;
    logic [3:0] release_dly = 4'h3;
    logic ov_above_trip, ov_below_release, power_good_out, power_good_oe;
    logic ss_start, latched_off, pre_por_ovp_en;
    logic [2:0] oc_retry_count;
    logic [7:0] ov_offset_mv, ocp_ref_ua, ocl_ref_ua;
    logic [10:0] ov_floor_mv;
    rfs_note_t notes[$];
    rfs_note_t cur;
    int failures = 0, num_checks = 0, cycles = 0, ss_pulses = 0;
    string what[12] = '{"high", "low", "pg_pull", "restart", "latched", "pre_por",
        "retries", "ov_offset", "ov_floor", "avg_limit", "ch_limit", "ch0_gates"};

    always #2.5 ref_clk = ~ref_clk;

    rfs_supervisor #(.DVT_HOLD_CYCLES(HOLD)) uut (
        .ref_clk(ref_clk), .rstn(rstn), .enable_in(enable_in), .por_ok(por_ok),
        .profile_two(profile_two), .ocp_method_two(ocp_method_two),
        .ov_above_trip(ov_above_trip), .ov_below_release(ov_below_release),
        .uv_below_trip(uv_below_trip), .uv_above_clear(uv_above_clear),
        .ocp_avg_above(ocp_avg_above), .ocp_current_monitor_voltage_above(ocp_current_monitor_voltage_above),
        .ocl_above(ocl_above), .ss_done(ss_done), .dvt_active(dvt_active),
        .pwm_high_req(pwm_high_req), .high_side_drive(high_side_drive),
        .low_side_drive(low_side_drive), .power_good_out(power_good_out),
        .power_good_oe(power_good_oe), .ss_start(ss_start), .latched_off(latched_off),
        .pre_por_ovp_en(pre_por_ovp_en), .oc_retry_count(oc_retry_count),
        .ov_offset_mv(ov_offset_mv), .ov_floor_mv(ov_floor_mv),
        .ocp_ref_ua(ocp_ref_ua), .ocl_ref_ua(ocl_ref_ua));

    rfs_stage_model stage (.ref_clk(ref_clk), .low_side_drive(low_side_drive),
        .ov_fault(ov_fault), .release_dly(release_dly),
        .ov_above_trip(ov_above_trip), .ov_below_release(ov_below_release));

    // --------------------
    // Result watching
    // --------------------
    function automatic logic [10:0] seen(input int sel);
        case (sel)
            0: return {9'h0, high_side_drive};
            1: return {9'h0, low_side_drive};
            2: return {10'h0, power_good_oe};
            3: return {10'h0, ss_start};
            4: return {10'h0, latched_off};
            5: return {10'h0, pre_por_ovp_en};
            7: return {3'h0, ov_offset_mv};
            8: return ov_floor_mv;
            9: return {3'h0, ocp_ref_ua};
            10: return {3'h0, ocl_ref_ua};
            11: return {9'h0, high_side_drive[0], low_side_drive[0]};
            default: return {8'h0, oc_retry_count};
        endcase
    endfunction

    task automatic compare(input string name, input logic [10:0] exp, input logic [10:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic note(input int sel, input logic [10:0] exp);
        notes.push_back('{sel, exp});
    endtask

    always @(negedge ref_clk) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            compare(what[cur.sel], cur.exp, seen(cur.sel));
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (ss_start === 1'b1)
            ss_pulses++;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end

    // --------------------
    // Stimulus helpers
    // --------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wait_hi(input int sel);
        int n;
        n = 0;
        while (seen(sel) !== 11'h1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        compare(what[sel], 11'h1, seen(sel));
        @(posedge ref_clk);
    endtask

    task automatic power_up();
        por_ok <= 1'b1;
        enable_in <= 1'b1;
        ss_done <= 1'b0;
        wait_hi(3);
    endtask

    task automatic finish_ss();
        cyc(2);
        ss_done <= 1'b1;
        cyc(2);
    endtask

    task automatic shut_down();
        enable_in <= 1'b0;
        cyc(5);
        note(4, 11'h0);
        note(6, 11'h0);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // --------------------
    // Main sequence
    // --------------------
    initial begin
        void'($urandom(32'hbec5));
        cyc(6);
        rstn <= 1'b1;
        cyc(2);
        note(0, 11'h0);
        note(1, 11'h0);
        note(5, 11'h1);
        note(9, 11'h64);
        power_up();
        note(7, 11'haf);
        note(8, 11'h4ec);
        note(2, 11'h1);
        note(5, 11'h0);
        finish_ss();
        note(8, 11'h0);
        note(2, 11'h0);
        pwm_high_req <= {1'($urandom), 1'b1};
        ocl_above <= 2'b01;
        cyc(4);
        note(11, 11'h1);
        ocl_above <= 2'b00;
        cyc(4);
        note(11, 11'h2);
        uv_below_trip <= 1'b1;
        uv_above_clear <= 1'b0;
        cyc(4);
        note(2, 11'h1);
        note(11, 11'h2);
        uv_below_trip <= 1'b0;
        uv_above_clear <= 1'b1;
        cyc(4);
        note(2, 11'h0);
        dvt_active <= 1'b1;
        cyc(3);
        note(9, 11'h8c);
        note(10, 11'hc4);
        dvt_active <= 1'b0;
        cyc(HOLD - 3);
        note(10, 11'hc4);
        cyc(8);
        note(9, 11'h64);
        note(10, 11'h8c);
        ss_pulses = 0;
        ocp_avg_above <= 1'b1;
        ss_done <= 1'b0;
        wait_hi(4);
        note(6, 11'h5);
        compare("retry_pulses", 11'h4, 11'(ss_pulses));
        ocp_avg_above <= 1'b0;
        shut_down();
        power_up();
        finish_ss();
        ocp_method_two <= 1'b1;
        cyc(6);
        note(6, 11'h0);
        ocp_current_monitor_voltage_above <= 1'b1;
        ss_done <= 1'b0;
        wait_hi(3);
        ocp_current_monitor_voltage_above <= 1'b0;
        note(6, 11'h2);
        finish_ss();
        note(6, 11'h0);
        release_dly <= 4'($urandom_range(9, 2));
        ov_fault <= 1'b1;
        cyc(4);
        note(1, 11'h3);
        note(0, 11'h0);
        note(2, 11'h1);
        wait_hi(4);
        ov_fault <= 1'b0;
        shut_down();
        profile_two <= 1'b1;
        power_up();
        note(7, 11'he1);
        ov_fault <= 1'b1;
        cyc(4);
        note(1, 11'h3);
        ov_fault <= 1'b0;
        cyc(20);
        note(4, 11'h0);
        ov_fault <= 1'b1;
        wait_hi(4);
        ov_fault <= 1'b0;
        por_ok <= 1'b0;
        cyc(5);
        note(5, 11'h1);
        note(4, 11'h0);
        cyc(2);
        results();
    end
endmodule

bind rfs_supervisor rfs_supervisor_sva #(.DVT_HOLD_CYCLES(DVT_HOLD_CYCLES)) u_sva (
    .ref_clk(ref_clk), .rstn(rstn), .enable_in(enable_in), .por_ok(por_ok),
    .ov_above_trip(ov_above_trip), .uv_below_trip(uv_below_trip),
    .dvt_active(dvt_active), .ocl_above(ocl_above),
    .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
    .power_good_oe(power_good_oe), .ss_start(ss_start), .latched_off(latched_off),
    .pre_por_ovp_en(pre_por_ovp_en), .oc_retry_count(oc_retry_count),
    .ocp_ref_ua(ocp_ref_ua), .ocl_ref_ua(ocl_ref_ua));

// ---- src/rfs_hold_timer.sv ----
/*
 * Stretches a level: output stays high while the input is high and for
 * HOLD_CYC clock cycles after it falls.
 * Assumes the input is already in the ref_clk domain.
 */
`timescale 1ns/1ps

module rfs_hold_timer #(
    parameter int HOLD_CYC = 10000
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic level_in,
    output logic stretched
);

    localparam int CW = $clog2(HOLD_CYC + 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic active;
    } rfs_hold_st_t;

    rfs_hold_st_t hold_reg;
    rfs_hold_st_t hold_next;

    always_comb begin
        hold_next = hold_reg;
        if (level_in) begin
            hold_next.count = CW'(HOLD_CYC);
        end else if (hold_reg.count != '0) begin
            hold_next.count = hold_reg.count - CW'(1);
        end
        hold_next.active = level_in || (hold_reg.count > CW'(1));
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hold_reg <= '0;
        end else begin
            hold_reg <= hold_next;
        end
    end

    assign stretched = hold_reg.active;

endmodule

// ---- src/rfs_params.svh ----
/*
 * Constants for the regulator fault supervisor: thresholds, timing and counts.
 * Assumes the including file follows with the package and the modules.
 */
`ifndef RFS_PARAMS_SVH
`define RFS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define RFS_NCH 2
`define RFS_SYNC_W 10

// ----------------------------------------------------------------------------
// Thresholds, in mV or uA
// ----------------------------------------------------------------------------
`define RFS_OV_FLOOR_MV 11'h4ec
`define RFS_OV_OFS_P1_MV 8'haf
`define RFS_OV_OFS_P2_MV 8'he1
`define RFS_OV_RELEASE_MV 8'h64
`define RFS_UV_TRIP_MV 9'h15e
`define RFS_UV_CLEAR_MV 9'h0fa
`define RFS_OCP_REF_UA 8'h64
`define RFS_OCP_BOOST_UA 8'h8c
`define RFS_OCL_REF_UA 8'h8c
`define RFS_OCL_BOOST_UA 8'hc4
`define RFS_OVERCURRENT_VOLTAGE_LIMIT_MV 12'h7d0

// ----------------------------------------------------------------------------
// Timing and counts
// ----------------------------------------------------------------------------
`define RFS_CLK_PERIOD_PS 5000
`define RFS_DVT_HOLD_NS 50000
`define RFS_DVT_HOLD_CYC ((`RFS_DVT_HOLD_NS * 1000) / `RFS_CLK_PERIOD_PS)
`define RFS_OC_RETRY_LIMIT 3'h5

`endif

// ---- src/rfs_pkg.sv ----
/*
 * Types for the regulator fault supervisor: control states and core state.
 * Assumes rfs_params.svh is on the include path.
 */
`include "rfs_params.svh"

package rfs_pkg;

    typedef enum logic [2:0] {
        RFS_SHUTDOWN,
        RFS_SOFTSTART,
        RFS_RUN,
        RFS_OC_OFF,
        RFS_OV_HOLD,
        RFS_LATCHED
    } rfs_state_t;

    typedef struct packed {
        rfs_state_t state;
        logic latched;
        logic clamp;
        logic ov_soft_seen;
        logic [2:0] oc_count;
        logic ss_ok;
        logic uv_low;
        logic ss_start;
        logic pg_pull;
        logic pg_level;
        logic pre_por;
        logic [`RFS_NCH-1:0] high;
        logic [`RFS_NCH-1:0] low;
        logic [7:0] ov_ofs_mv;
        logic [10:0] ov_floor_mv;
        logic [7:0] ocp_ref_ua;
        logic [7:0] ocl_ref_ua;
    } rfs_core_t;

endpackage

// ---- src/rfs_supervisor.sv ----
/*
 * Fault supervisor of a multi-phase regulator controller. Takes comparator
 * results for overvoltage, undervoltage, average overcurrent and per-channel
 * current limit, plus soft-start and voltage-transition status, and drives
 * the gate commands, power-good, threshold selects and the retry counter.
 * Assumes: comparator and pin inputs are asynchronous; soft-start status,
 * transition status and PWM requests come from logic on ref_clk; the analog
 * comparators use the threshold values this block drives out.
 */
`timescale 1ns/1ps
`include "rfs_params.svh"

module rfs_supervisor #(
    parameter int DVT_HOLD_CYCLES = `RFS_DVT_HOLD_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic enable_in,
    input wire logic por_ok,
    input wire logic profile_two,
    input wire logic ocp_method_two,
    input wire logic ov_above_trip,
    input wire logic ov_below_release,
    input wire logic uv_below_trip,
    input wire logic uv_above_clear,
    input wire logic ocp_avg_above,
    input wire logic ocp_current_monitor_voltage_above,
    input wire logic [`RFS_NCH-1:0] ocl_above,
    input wire logic ss_done,
    input wire logic dvt_active,
    input wire logic [`RFS_NCH-1:0] pwm_high_req,
    output logic [`RFS_NCH-1:0] high_side_drive,
    output logic [`RFS_NCH-1:0] low_side_drive,
    output logic power_good_out,
    output logic power_good_oe,
    output logic ss_start,
    output logic latched_off,
    output logic pre_por_ovp_en,
    output logic [2:0] oc_retry_count,
    output logic [7:0] ov_offset_mv,
    output logic [10:0] ov_floor_mv,
    output logic [7:0] ocp_ref_ua,
    output logic [7:0] ocl_ref_ua
);

    // ------------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------------
    logic [`RFS_SYNC_W+`RFS_NCH-1:0] raw_in;
    logic [`RFS_SYNC_W+`RFS_NCH-1:0] sync_in;
    logic en_s;
    logic por_s;
    logic prof2_s;
    logic meth2_s;
    logic ov_trip_s;
    logic ov_rel_s;
    logic uv_trip_s;
    logic uv_clear_s;
    logic ocp_avg_s;
    logic ocp_current_monitor_voltage_s;
    logic [`RFS_NCH-1:0] ocl_s;

    assign raw_in = {ocl_above, ocp_current_monitor_voltage_above, ocp_avg_above, uv_above_clear,
                     uv_below_trip, ov_below_release, ov_above_trip,
                     ocp_method_two, profile_two, por_ok, enable_in};

    rfs_sync #(
        .W(`RFS_SYNC_W + `RFS_NCH)
    ) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    assign en_s = sync_in[0];
    assign por_s = sync_in[1];
    assign prof2_s = sync_in[2];
    assign meth2_s = sync_in[3];
    assign ov_trip_s = sync_in[4];
    assign ov_rel_s = sync_in[5];
    assign uv_trip_s = sync_in[6];
    assign uv_clear_s = sync_in[7];
    assign ocp_avg_s = sync_in[8];
    assign ocp_current_monitor_voltage_s = sync_in[9];
    assign ocl_s = sync_in[`RFS_SYNC_W+`RFS_NCH-1:`RFS_SYNC_W];

    // ------------------------------------------------------------------------
    // Transition boost window
    // ------------------------------------------------------------------------
    logic boost;

    rfs_hold_timer #(
        .HOLD_CYC(DVT_HOLD_CYCLES)
    ) u_boost (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .level_in(dvt_active),
        .stretched(boost)
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic is_active(input rfs_pkg::rfs_state_t st);
        is_active = (st == rfs_pkg::RFS_SOFTSTART) || (st == rfs_pkg::RFS_RUN);
    endfunction

    // ------------------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------------------
    rfs_pkg::rfs_core_t core_reg;
    rfs_pkg::rfs_core_t core_next;

    logic enabled;
    logic oc_trip;
    logic ov_start;
    logic pg_ok;

    assign enabled = en_s && por_s;
    assign oc_trip = meth2_s ? ocp_current_monitor_voltage_s : ocp_avg_s;

    always_comb begin
        core_next = core_reg;
        core_next.ss_start = 1'b0;
        core_next.pg_level = 1'b0;
        core_next.pre_por = !por_s;
        ov_start = ov_trip_s && !core_reg.clamp;
        pg_ok = 1'b0;

        if (!enabled) begin
            // Enable low or supply below POR clears every latch except the undervoltage flag
            core_next.state = rfs_pkg::RFS_SHUTDOWN;
            core_next.clamp = 1'b0;
            core_next.ov_soft_seen = 1'b0;
            core_next.oc_count = 3'h0;
            core_next.ss_ok = 1'b0;
        end else begin
            // Clamp is armed by any trip outside the shutdown state, released 100mV under the trip level
            if (core_reg.state != rfs_pkg::RFS_SHUTDOWN) begin
                if (ov_start) begin
                    core_next.clamp = 1'b1;
                end else if (core_reg.clamp && ov_rel_s) begin
                    core_next.clamp = 1'b0;
                end
            end

            case (core_reg.state)
                rfs_pkg::RFS_SHUTDOWN: begin
                    core_next.state = rfs_pkg::RFS_SOFTSTART;
                    core_next.ss_start = 1'b1;
                end
                rfs_pkg::RFS_SOFTSTART: begin
                    if (ov_start) begin
                        core_next.ss_ok = 1'b0;
                        if (!core_reg.ov_soft_seen) begin
                            core_next.ov_soft_seen = 1'b1;
                        end else begin
                            core_next.state = rfs_pkg::RFS_OV_HOLD;
                        end
                    end else if (oc_trip) begin
                        core_next.state = rfs_pkg::RFS_OC_OFF;
                        core_next.oc_count = core_reg.oc_count + 3'h1;
                    end else if (ss_done && !core_reg.clamp) begin
                        core_next.state = rfs_pkg::RFS_RUN;
                        core_next.ss_ok = 1'b1;
                        core_next.oc_count = 3'h0;
                    end
                end
                rfs_pkg::RFS_RUN: begin
                    if (ov_start) begin
                        core_next.state = rfs_pkg::RFS_OV_HOLD;
                        core_next.ss_ok = 1'b0;
                    end else if (oc_trip) begin
                        core_next.state = rfs_pkg::RFS_OC_OFF;
                        core_next.ss_ok = 1'b0;
                        core_next.oc_count = core_reg.oc_count + 3'h1;
                    end
                end
                rfs_pkg::RFS_OC_OFF: begin
                    if (core_reg.oc_count >= `RFS_OC_RETRY_LIMIT) begin
                        core_next.state = rfs_pkg::RFS_LATCHED;
                    end else begin
                        core_next.state = rfs_pkg::RFS_SOFTSTART;
                        core_next.ss_start = 1'b1;
                    end
                end
                rfs_pkg::RFS_OV_HOLD: begin
                    if (!core_next.clamp) begin
                        core_next.state = rfs_pkg::RFS_LATCHED;
                    end
                end
                rfs_pkg::RFS_LATCHED: begin
                    core_next.state = rfs_pkg::RFS_LATCHED;
                end
                default: begin
                    core_next.state = rfs_pkg::RFS_SHUTDOWN;
                end
            endcase
        end

        core_next.latched = core_next.state == rfs_pkg::RFS_LATCHED;
        // Undervoltage flag with hysteresis; trip wins over clear
        if (uv_trip_s) begin
            core_next.uv_low = 1'b1;
        end else if (uv_clear_s) begin
            core_next.uv_low = 1'b0;
        end

        // Power-good: profile one also needs the run state
        if (!prof2_s) begin
            pg_ok = core_next.ss_ok && !core_next.uv_low && !core_next.clamp
                    && (core_next.state == rfs_pkg::RFS_RUN);
        end else begin
            pg_ok = core_next.ss_ok && !core_next.uv_low && !core_next.clamp
                    && (core_next.state != rfs_pkg::RFS_OC_OFF);
        end
        core_next.pg_pull = !pg_ok;

        // Gate commands
        for (int i = 0; i < `RFS_NCH; i++) begin
            core_next.high[i] = is_active(core_next.state) && !core_next.clamp
                                && pwm_high_req[i] && !ocl_s[i];
            core_next.low[i] = core_next.clamp
                               || (is_active(core_next.state)
                                   && (!pwm_high_req[i] || ocl_s[i]));
        end

        // Overvoltage level: frozen while clamped so release tracks the trip
        if (!core_next.clamp) begin
            core_next.ov_ofs_mv = prof2_s ? `RFS_OV_OFS_P2_MV : `RFS_OV_OFS_P1_MV;
            if (core_next.state == rfs_pkg::RFS_SOFTSTART && !prof2_s) begin
                core_next.ov_floor_mv = `RFS_OV_FLOOR_MV;
            end else begin
                core_next.ov_floor_mv = 11'h000;
            end
        end

        // Current references, boosted around voltage transitions
        core_next.ocp_ref_ua = boost ? `RFS_OCP_BOOST_UA : `RFS_OCP_REF_UA;
        core_next.ocl_ref_ua = boost ? `RFS_OCL_BOOST_UA : `RFS_OCL_REF_UA;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            core_reg <= '{
                state: rfs_pkg::RFS_SHUTDOWN,
                latched: 1'b0,
                clamp: 1'b0,
                ov_soft_seen: 1'b0,
                oc_count: 3'h0,
                ss_ok: 1'b0,
                uv_low: 1'b0,
                ss_start: 1'b0,
                pg_pull: 1'b1,
                pg_level: 1'b0,
                pre_por: 1'b1,
                high: '0,
                low: '0,
                ov_ofs_mv: 8'h00,
                ov_floor_mv: 11'h000,
                ocp_ref_ua: `RFS_OCP_REF_UA,
                ocl_ref_ua: `RFS_OCL_REF_UA
            };
        end else begin
            core_reg <= core_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign high_side_drive = core_reg.high;
    assign low_side_drive = core_reg.low;
    assign power_good_out = core_reg.pg_level;
    assign power_good_oe = core_reg.pg_pull;
    assign ss_start = core_reg.ss_start;
    assign latched_off = core_reg.latched;
    assign pre_por_ovp_en = core_reg.pre_por;
    assign oc_retry_count = core_reg.oc_count;
    assign ov_offset_mv = core_reg.ov_ofs_mv;
    assign ov_floor_mv = core_reg.ov_floor_mv;
    assign ocp_ref_ua = core_reg.ocp_ref_ua;
    assign ocl_ref_ua = core_reg.ocl_ref_ua;

endmodule

// ---- src/rfs_sync.sv ----
/*
 * Two-stage synchroniser for a bus of independent level inputs.
 * Assumes each bit is a slow comparator or pin level; no bus coherence kept.
 */
`timescale 1ns/1ps

module rfs_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } rfs_sync_st_t;

    rfs_sync_st_t sync_reg;
    rfs_sync_st_t sync_next;

    always_comb begin
        sync_next.meta = async_in;
        sync_next.stable = sync_reg.meta;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.stable;

endmodule
